// ---- bench/pin_load.sv ----
// external load on the waveform output pin
`timescale 1ns/1ps
module pin_load (
  input wire logic drive,
  input wire logic enable,
  output logic level
);
  // ==========
  // released pin rests at the pull-up level, never the last value
  assign level = enable ? drive : 1'b1;
endmodule

// ---- bench/timer8_waveform_modes_sva.sv ----
// assertion checker for the 8-bit waveform timer
`timescale 1ns/1ps
module timer8_waveform_modes_sva (
  input wire logic mclk,
  input wire logic rstn,
  input wire timer8_pkg::timer_cfg_type cfg,
  input wire logic [1:0] force_compare_strobe,
  input wire logic counter_wr_en,
  input wire timer8_pkg::timer_flags_type flag_clear,
  input wire timer8_pkg::timer_flags_type int_serviced,
  input wire logic [1:0] pin_dir_out,
  input wire logic [1:0] port_data,
  input wire logic [7:0] counter_value,
  input wire logic [7:0] compare_value_a,
  input wire timer8_pkg::timer_flags_type flags,
  input wire logic [1:0] compare_output_state,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe
);
  // ==========
  // helpers
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic nrm;
  logic div1;
  assign nrm = cfg.waveform_mode_select == timer8_pkg::mode_normal;
  assign div1 = cfg.clock_select == timer8_pkg::cs_div1;
  sequence wrap_s;
    counter_value == 8'hff ##1 counter_value == 8'h00;
  endsequence
  sequence top_clear_s;
    counter_value == compare_value_a ##1 counter_value == 8'h00;
  endsequence
  // ==========
  // properties
  dir_follow_a: assert property (
    $past(rstn) |-> pin_oe == $past(pin_dir_out)) else $error("pin enable wrong");
  port_pass_a: assert property (
    $past(rstn) && $past(cfg.compare_output_action_a) == timer8_pkg::act_none
    |-> pin_out[0] == $past(port_data[0])) else $error("port value not passed");
  port_pass_b_a: assert property (
    $past(rstn) && $past(cfg.compare_output_action_b) == timer8_pkg::act_none
    |-> pin_out[1] == $past(port_data[1])) else $error("port value not passed on b");
  no_action_a: assert property (
    $past(rstn) && $past(cfg.compare_output_action_a) == timer8_pkg::act_none
    |-> compare_output_state[0] == $past(compare_output_state[0])) else $error("state moved");
  force_set_a: assert property (
    $past(rstn) && nrm && force_compare_strobe[0] && cfg.compare_output_action_a == timer8_pkg::act_set
    |-> ##[1:2] compare_output_state[0]) else $error("force ignored");
  ovf_sticky_a: assert property (
    $past(rstn) && $past(flags.overflow) && !$past(flag_clear.overflow) && !$past(int_serviced.overflow)
    |-> flags.overflow) else $error("overflow lost");
  ovf_wrap_a: assert property (
    nrm && $rose(flags.overflow) && !$past(counter_wr_en) |-> wrap_s) else $error("overflow misplaced");
  match_next_a: assert property (
    nrm && $rose(flags.match_a) |-> counter_value == compare_value_a) else $error("match flag misplaced");
  ctc_clear_a: assert property (
    cfg.waveform_mode_select == timer8_pkg::mode_clear_on_match && $rose(flags.match_a)
    && !$past(counter_wr_en) |-> top_clear_s) else $error("no clear at top");
  cnt_step_a: assert property (
    $past(rstn, 3) && nrm && div1 && $past(cfg) == cfg && $past(cfg, 2) == cfg && $past(cfg, 3) == cfg
    && !$past(counter_wr_en) && !$past(counter_wr_en, 2)
    |-> counter_value == $past(counter_value) + 8'h01) else $error("count step wrong");
  fast_top_a: assert property (
    cfg.waveform_mode_select == timer8_pkg::mode_fast_max && div1 && $past(cfg) == cfg
    && $past(cfg, 2) == cfg && !$past(counter_wr_en) && counter_value == 8'hff
    |=> counter_value == 8'h00) else $error("no restart after top");
endmodule

bind timer8_waveform_modes timer8_waveform_modes_sva u_sva (.mclk(mclk), .rstn(rstn), .cfg(cfg),
  .force_compare_strobe(force_compare_strobe), .counter_wr_en(counter_wr_en), .flag_clear(flag_clear),
  .int_serviced(int_serviced), .pin_dir_out(pin_dir_out), .port_data(port_data),
  .counter_value(counter_value), .compare_value_a(compare_value_a), .flags(flags),
  .compare_output_state(compare_output_state), .pin_out(pin_out), .pin_oe(pin_oe));

// ---- bench/timer8_waveform_modes_tb.sv ----
// self-checking testbench for the 8-bit waveform timer
`timescale 1ns/1ps
module timer8_waveform_modes_tb;
  logic mclk;
  logic rstn;
  timer8_pkg::timer_cfg_type cfg;
  logic [1:0] force_compare_strobe;
  logic counter_wr_en;
  logic [7:0] counter_wr_data;
  logic [1:0] compare_wr_en;
  logic [7:0] compare_wr_data;
  timer8_pkg::timer_flags_type flag_clear;
  timer8_pkg::timer_flags_type int_serviced;
  logic [1:0] pin_dir_out;
  logic [1:0] port_data;
  logic [7:0] counter_value;
  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  timer8_pkg::timer_flags_type flags;
  logic [1:0] compare_output_state;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic pin_level;
  int mismatches;
  int checks_done;
  timer8_waveform_modes u_dut (.mclk(mclk), .rstn(rstn), .cfg(cfg), .force_compare_strobe(force_compare_strobe),
    .counter_wr_en(counter_wr_en), .counter_wr_data(counter_wr_data), .compare_wr_en(compare_wr_en),
    .compare_wr_data(compare_wr_data), .flag_clear(flag_clear), .int_serviced(int_serviced),
    .pin_dir_out(pin_dir_out), .port_data(port_data), .counter_value(counter_value),
    .compare_value_a(compare_value_a), .compare_value_b(compare_value_b), .flags(flags),
    .compare_output_state(compare_output_state), .pin_out(pin_out), .pin_oe(pin_oe));
  pin_load u_load (.drive(pin_out[0]), .enable(pin_oe[0]), .level(pin_level));
  // ==========
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic set_mode(input logic [2:0] m, input logic [1:0] a);
    @(posedge mclk);
    cfg.waveform_mode_select <= m;
    cfg.compare_output_action_a <= a;
  endtask
  task automatic wr_cnt(input logic [7:0] v);
    @(posedge mclk);
    counter_wr_en <= 1'b1;
    counter_wr_data <= v;
    @(posedge mclk);
    counter_wr_en <= 1'b0;
  endtask
  task automatic wr_cmp(input logic [7:0] v);
    @(posedge mclk);
    compare_wr_en <= 2'b01;
    compare_wr_data <= v;
    @(posedge mclk);
    compare_wr_en <= 2'b00;
  endtask
  task automatic pulse_clr(input logic [2:0] v);
    @(posedge mclk);
    flag_clear <= v;
    @(posedge mclk);
    flag_clear <= 3'h0;
  endtask
  task automatic observe(input int n, output int hi, output int tg, output logic [7:0] mx);
    logic prev;
    hi = 0;
    tg = 0;
    mx = 8'h00;
    prev = pin_level;
    repeat (n) begin
      cyc(1);
      if (pin_level === 1'b1) hi++;
      if (pin_level !== prev) tg++;
      prev = pin_level;
      if (counter_value > mx) mx = counter_value;
    end
  endtask
  task automatic final_report;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_normal;
    set_mode(timer8_pkg::mode_normal, timer8_pkg::act_none);
    cfg.clock_select <= timer8_pkg::cs_div1;
    pulse_clr(3'h7);
    wr_cnt(8'hfe);
    cyc(4);
    chk(flags.overflow, 1'b1);
    pulse_clr(3'h3);
    cyc(2);
    chk(flags.overflow, 1'b1);
    pulse_clr(3'h4);
    cyc(2);
    chk(flags.overflow, 1'b0);
    wr_cnt(8'hfe);
    cyc(4);
    chk(flags.overflow, 1'b1);
    @(posedge mclk);
    int_serviced <= 3'h4;
    @(posedge mclk);
    int_serviced <= 3'h0;
    cyc(2);
    chk(flags.overflow, 1'b0);
  endtask
  task automatic t_block;
    wr_cnt(8'h00);
    wr_cmp(8'h40);
    pulse_clr(3'h7);
    wr_cnt(8'h40);
    cyc(6);
    chk(flags.match_a, 1'b0);
    wr_cnt(8'h3e);
    cyc(6);
    chk(flags.match_a, 1'b1);
    @(posedge mclk);
    compare_wr_en <= 2'b10;
    compare_wr_data <= 8'h60;
    @(posedge mclk);
    compare_wr_en <= 2'b00;
    cyc(1);
    chk(flags.match_b, 1'b0);
    cyc(29);
    chk(compare_value_b, 8'h60);
    chk(flags.match_b, 1'b1);
  endtask
  task automatic t_force;
    logic [1:0] acts [4];
    logic st [4];
    acts = '{timer8_pkg::act_set, timer8_pkg::act_clear, timer8_pkg::act_toggle, timer8_pkg::act_none};
    st = '{1'b1, 1'b0, 1'b1, 1'b1};
    wr_cnt(8'h00);
    wr_cmp(8'h80);
    for (int i = 0; i < 4; i++) begin
      set_mode(timer8_pkg::mode_normal, acts[i]);
      @(posedge mclk);
      force_compare_strobe <= 2'b01;
      @(posedge mclk);
      force_compare_strobe <= 2'b00;
      cyc(3);
      chk(compare_output_state[0], st[i]);
      chk(pin_level, (i < 3) ? st[i] : port_data[0]);
    end
  endtask
  task automatic t_ctc;
    int hi;
    int tg;
    logic [7:0] mx;
    set_mode(timer8_pkg::mode_clear_on_match, timer8_pkg::act_toggle);
    wr_cmp(8'h05);
    wr_cnt(8'h00);
    pulse_clr(3'h7);
    cyc(3);
    observe(60, hi, tg, mx);
    chk(mx, 8'h05);
    chk(tg, 10);
    chk(flags.match_a, 1'b1);
    pulse_clr(3'h7);
    wr_cnt(8'h10);
    cyc(250);
    chk(flags.overflow, 1'b1);
  endtask
  task automatic t_pwm;
    logic [7:0] pc [5];
    logic [1:0] pa [5];
    int ph [5];
    int hi;
    int tg;
    logic [7:0] mx;
    pc = '{8'h80, 8'h80, 8'hff, 8'h00, 8'h00};
    pa = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h3};
    ph = '{129, 127, 256, 1, 255};
    for (int i = 0; i < 5; i++) begin
      set_mode(timer8_pkg::mode_fast_max, pa[i]);
      wr_cmp(pc[i]);
      cyc(2);
      chk(compare_value_a, pc[i]);
      cyc(300);
      observe(256, hi, tg, mx);
      chk(hi, ph[i]);
      chk(mx, 8'hff);
    end
    set_mode(timer8_pkg::mode_fast_cmp, timer8_pkg::act_toggle);
    wr_cmp(8'h03);
    cyc(300);
    observe(64, hi, tg, mx);
    chk(tg, 16);
    chk(mx, 8'h03);
  endtask
  task automatic t_div;
    int dv [7];
    logic [7:0] c0;
    logic [7:0] d;
    dv = '{1, 8, 32, 64, 128, 256, 1024};
    set_mode(timer8_pkg::mode_normal, timer8_pkg::act_none);
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk);
      cfg.clock_select <= 3'(i + 1);
      cyc(2 * dv[i] + 2);
      c0 = counter_value;
      cyc(20 * dv[i]);
      d = counter_value - c0;
      chk(d >= 8'd19 && d <= 8'd21, 1'b1);
    end
  endtask
  // ==========
  // clock, watchdog and main sequence
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #500000;
    mismatches++;
    final_report();
  end
  initial begin
    mismatches = 0;
    checks_done = 0;
    rstn = 1'b0;
    cfg = '0;
    force_compare_strobe = 2'b00;
    counter_wr_en = 1'b0;
    counter_wr_data = 8'h00;
    compare_wr_en = 2'b00;
    compare_wr_data = 8'h00;
    flag_clear = 3'h0;
    int_serviced = 3'h0;
    pin_dir_out = 2'b00;
    port_data = 2'b10;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    cyc(2);
    chk({counter_value, 5'h00, flags}, 16'h0000);
    chk(pin_level, 1'b1);
    pin_dir_out <= 2'b01;
    t_normal();
    t_block();
    t_force();
    t_ctc();
    t_pwm();
    t_div();
    final_report();
  end
endmodule

// ---- hw/timer8_compare_output.sv ----
// one compare output state bit with its waveform actions
`timescale 1ns/1ps
module timer8_compare_output (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic pwm_mode,
  input wire logic fast_pwm,
  input wire logic toggle_in_pwm,
  input wire logic [1:0] action,
  input wire logic match,
  input wire logic bottom,
  input wire logic force_strobe,
  output logic state_q
);

  function automatic logic apply(input logic [1:0] act, input logic cur);
    logic r;
    r = cur;
    unique case (act)
      timer8_pkg::act_none: r = cur;
      timer8_pkg::act_toggle: r = ~cur;
      timer8_pkg::act_clear: r = 1'b0;
      timer8_pkg::act_set: r = 1'b1;
    endcase
    return r;
  endfunction

  // ==========================================================
  // output state
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q <= 1'b0;
    end else if (!pwm_mode) begin
      // force applies the action at once
      if (force_strobe || match) begin
        state_q <= apply(action, state_q);
      end
    end else if (fast_pwm) begin
      // bottom restores the level, wins over match so a max compare stays constant
      if (bottom && (action == timer8_pkg::act_clear)) begin
        state_q <= 1'b1;
      end else if (bottom && (action == timer8_pkg::act_set)) begin
        state_q <= 1'b0;
      end else if (match && (action == timer8_pkg::act_clear)) begin
        state_q <= 1'b0;
      end else if (match && (action == timer8_pkg::act_set)) begin
        state_q <= 1'b1;
      end else if (match && toggle_in_pwm && (action == timer8_pkg::act_toggle)) begin
        // toggle per match gives half duty
        state_q <= ~state_q;
      end
    end
  end

endmodule

// ---- hw/timer8_pkg.sv ----
// constants, types and mode decoding shared by the 8-bit timer files
package timer8_pkg;

  // ==========================================================
  // counter geometry and reset values
  localparam int unsigned cnt_width = 8;
  localparam int unsigned num_channels = 2;
  localparam logic [7:0] count_max = 8'hff;
  localparam logic [7:0] count_bottom = 8'h00;
  localparam logic [7:0] count_step = 8'h01;
  localparam logic [7:0] counter_reset = 8'h00;
  localparam logic [7:0] compare_reset = 8'h00;

  // ==========================================================
  // channel indices
  localparam int unsigned chan_a = 0;
  localparam int unsigned chan_b = 1;

  // ==========================================================
  // waveform mode select encodings
  localparam logic [2:0] mode_normal = 3'h0;
  localparam logic [2:0] mode_phase_max = 3'h1;
  localparam logic [2:0] mode_clear_on_match = 3'h2;
  localparam logic [2:0] mode_fast_max = 3'h3;
  localparam logic [2:0] mode_phase_cmp = 3'h5;
  localparam logic [2:0] mode_fast_cmp = 3'h7;

  // ==========================================================
  // compare output action encodings
  localparam logic [1:0] act_none = 2'h0;
  localparam logic [1:0] act_toggle = 2'h1;
  localparam logic [1:0] act_clear = 2'h2;
  localparam logic [1:0] act_set = 2'h3;

  // ==========================================================
  // prescaler selections and division factors
  localparam logic [2:0] cs_stop = 3'h0;
  localparam logic [2:0] cs_div1 = 3'h1;
  localparam logic [2:0] cs_div8 = 3'h2;
  localparam logic [2:0] cs_div32 = 3'h3;
  localparam logic [2:0] cs_div64 = 3'h4;
  localparam logic [2:0] cs_div128 = 3'h5;
  localparam logic [2:0] cs_div256 = 3'h6;
  localparam logic [2:0] cs_div1024 = 3'h7;
  localparam int unsigned div_width = 10;
  localparam logic [10:0] div_1 = 11'h001;
  localparam logic [10:0] div_8 = 11'h008;
  localparam logic [10:0] div_32 = 11'h020;
  localparam logic [10:0] div_64 = 11'h040;
  localparam logic [10:0] div_128 = 11'h080;
  localparam logic [10:0] div_256 = 11'h100;
  localparam logic [10:0] div_1024 = 11'h400;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [2:0] clock_select;
    logic [2:0] waveform_mode_select;
    logic [1:0] compare_output_action_b;
    logic [1:0] compare_output_action_a;
  } timer_cfg_type;

  typedef struct packed {
    logic overflow;
    logic match_b;
    logic match_a;
  } timer_flags_type;

  // ==========================================================
  // mode decoding
  function automatic logic is_fast_pwm(input logic [2:0] mode);
    return (mode == mode_fast_max) || (mode == mode_fast_cmp);
  endfunction

  function automatic logic is_pwm(input logic [2:0] mode);
    return is_fast_pwm(mode) || (mode == mode_phase_max) || (mode == mode_phase_cmp);
  endfunction

  function automatic logic top_is_compare(input logic [2:0] mode);
    return (mode == mode_clear_on_match) || (mode == mode_fast_cmp) || (mode == mode_phase_cmp);
  endfunction

endpackage

// ---- hw/timer8_prescaler.sv ----
// timer clock enable divider for the 8-bit timer
`timescale 1ns/1ps
module timer8_prescaler (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [2:0] clock_select,
  output logic tick_q
);

  // ==========================================================
  // division factor decode
  function automatic logic [10:0] divisor(input logic [2:0] sel);
    logic [10:0] d;
    d = timer8_pkg::div_1;
    unique case (sel)
      timer8_pkg::cs_div8: d = timer8_pkg::div_8;
      timer8_pkg::cs_div32: d = timer8_pkg::div_32;
      timer8_pkg::cs_div64: d = timer8_pkg::div_64;
      timer8_pkg::cs_div128: d = timer8_pkg::div_128;
      timer8_pkg::cs_div256: d = timer8_pkg::div_256;
      timer8_pkg::cs_div1024: d = timer8_pkg::div_1024;
      default: d = timer8_pkg::div_1;
    endcase
    return d;
  endfunction

  logic [timer8_pkg::div_width-1:0] div_q;
  logic [timer8_pkg::div_width-1:0] limit;
  logic [10:0] limit_full;

  assign limit_full = divisor(clock_select) - timer8_pkg::div_1;
  assign limit = limit_full[timer8_pkg::div_width-1:0];

  // ==========================================================
  // divider
  // selectable system clock division
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (clock_select == timer8_pkg::cs_stop) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q >= limit) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

endmodule

// ---- hw/timer8_waveform_modes.sv ----
// 8-bit timer counter with compare channels and waveform generation
`timescale 1ns/1ps
module timer8_waveform_modes (
  input wire logic mclk,
  input wire logic rstn,
  input wire timer8_pkg::timer_cfg_type cfg,
  input wire logic [1:0] force_compare_strobe,
  input wire logic counter_wr_en,
  input wire logic [7:0] counter_wr_data,
  input wire logic [1:0] compare_wr_en,
  input wire logic [7:0] compare_wr_data,
  input wire timer8_pkg::timer_flags_type flag_clear,
  input wire timer8_pkg::timer_flags_type int_serviced,
  input wire logic [1:0] pin_dir_out,
  input wire logic [1:0] port_data,
  output logic [7:0] counter_value,
  output logic [7:0] compare_value_a,
  output logic [7:0] compare_value_b,
  output timer8_pkg::timer_flags_type flags,
  output logic [1:0] compare_output_state,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe
);

  // ==========================================================
  // mode decode
  logic [2:0] mode;
  logic pwm_mode;
  logic fast_pwm;
  logic top_cmp;
  logic [1:0] action [timer8_pkg::num_channels];

  assign mode = cfg.waveform_mode_select;
  assign pwm_mode = timer8_pkg::is_pwm(mode);
  assign fast_pwm = timer8_pkg::is_fast_pwm(mode);
  assign top_cmp = timer8_pkg::top_is_compare(mode);
  assign action[timer8_pkg::chan_a] = cfg.compare_output_action_a;
  assign action[timer8_pkg::chan_b] = cfg.compare_output_action_b;

  // ==========================================================
  // timer clock enable
  logic tick;

  timer8_prescaler u_prescaler (
    .mclk(mclk),
    .rstn(rstn),
    .clock_select(cfg.clock_select),
    .tick_q(tick)
  );

  // ==========================================================
  // counter
  logic [7:0] cnt_q;
  logic [7:0] cnt_inc;
  logic [7:0] top_value;
  logic at_top;
  logic at_max;
  logic block_q;
  logic [7:0] active_q [timer8_pkg::num_channels];
  logic [7:0] buffer_q [timer8_pkg::num_channels];

  assign cnt_inc = 8'(cnt_q + timer8_pkg::count_step);
  // top is compare A in modes 2, 5 and 7, max in every other mode
  assign top_value = top_cmp ? active_q[timer8_pkg::chan_a] : timer8_pkg::count_max;
  assign at_top = (cnt_q == top_value);
  assign at_max = (cnt_q == timer8_pkg::count_max);

  // only the mode selects the sequence
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_q <= timer8_pkg::counter_reset;
    end else if (counter_wr_en) begin
      cnt_q <= counter_wr_data;
    end else if (tick) begin
      unique case (mode)
        timer8_pkg::mode_clear_on_match: begin
          // a missed top runs on through the wrap
          cnt_q <= at_top ? timer8_pkg::count_bottom : cnt_inc;
        end
        timer8_pkg::mode_fast_max, timer8_pkg::mode_fast_cmp: begin
          // bottom on the tick after top
          cnt_q <= at_top ? timer8_pkg::count_bottom : cnt_inc;
        end
        default: begin
          cnt_q <= cnt_inc;
        end
      endcase
    end
  end

  // a write blocks the following tick's match, even while stopped
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      block_q <= 1'b0;
    end else if (counter_wr_en) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // ==========================================================
  // events on a timer tick
  logic match_en;
  logic overflow_evt;
  logic bottom_evt;
  logic update_evt;
  logic [1:0] match_evt;

  assign match_en = tick && !block_q && !counter_wr_en;
  // normal and clear-on-match flag the wrap to zero
  assign overflow_evt = tick && !counter_wr_en && (fast_pwm ? at_top : at_max);
  assign bottom_evt = tick && !counter_wr_en && fast_pwm && at_top;
  // buffered value moves over at top
  assign update_evt = tick && !counter_wr_en && pwm_mode && at_top;

  // ==========================================================
  // compare channels
  genvar ch;
  generate
    for (ch = 0; ch < timer8_pkg::num_channels; ch++) begin : g_chan
      assign match_evt[ch] = match_en && (cnt_q == active_q[ch]);

      always_ff @(posedge mclk) begin
        if (!rstn) begin
          buffer_q[ch] <= timer8_pkg::compare_reset;
        end else if (compare_wr_en[ch]) begin
          buffer_q[ch] <= compare_wr_data;
        end
      end

      always_ff @(posedge mclk) begin
        if (!rstn) begin
          active_q[ch] <= timer8_pkg::compare_reset;
        end else if (!pwm_mode) begin
          if (compare_wr_en[ch]) begin
            active_q[ch] <= compare_wr_data;
          end
        end else if (update_evt) begin
          // PWM writes reach the comparator only via the buffer
          active_q[ch] <= buffer_q[ch];
        end
      end

      // extreme compare values handled by bottom priority
      timer8_compare_output u_output (
        .mclk(mclk),
        .rstn(rstn),
        .pwm_mode(pwm_mode),
        .fast_pwm(fast_pwm),
        .toggle_in_pwm((ch == timer8_pkg::chan_a) && (mode == timer8_pkg::mode_fast_cmp)),
        .action(action[ch]),
        .match(match_evt[ch]),
        .bottom(bottom_evt),
        .force_strobe(force_compare_strobe[ch] && !pwm_mode),
        .state_q(compare_output_state[ch])
      );

      // pin driven only when direction is output
      always_ff @(posedge mclk) begin
        if (!rstn) begin
          pin_out[ch] <= 1'b0;
          pin_oe[ch] <= 1'b0;
        end else begin
          pin_out[ch] <= (action[ch] != timer8_pkg::act_none) ? compare_output_state[ch] : port_data[ch];
          pin_oe[ch] <= pin_dir_out[ch];
        end
      end
    end
  endgenerate

  // ==========================================================
  // flags, set wins over any clear
  // match flag set by the tick that sees equality
  // in clear-on-match top match flags A
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flags <= '0;
    end else begin
      flags.match_a <= match_evt[timer8_pkg::chan_a] ||
                       (flags.match_a && !flag_clear.match_a && !int_serviced.match_a);
      flags.match_b <= match_evt[timer8_pkg::chan_b] ||
                       (flags.match_b && !flag_clear.match_b && !int_serviced.match_b);
      flags.overflow <= overflow_evt ||
                        (flags.overflow && !flag_clear.overflow && !int_serviced.overflow);
    end
  end

  // ==========================================================
  // readback
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      counter_value <= timer8_pkg::counter_reset;
      compare_value_a <= timer8_pkg::compare_reset;
      compare_value_b <= timer8_pkg::compare_reset;
    end else begin
      counter_value <= cnt_q;
      compare_value_a <= buffer_q[timer8_pkg::chan_a];
      compare_value_b <= buffer_q[timer8_pkg::chan_b];
    end
  end

endmodule
